// ==== design/pcseq_map.svh ====
`ifndef PCSEQ_MAP_SVH
`define PCSEQ_MAP_SVH

// ----------------------------------------
// Address layout and reset values
// ----------------------------------------
`define PCSEQ_PC_WIDTH        11
`define PCSEQ_PC_RESET        11'h000
`define PCSEQ_SHORT_LSB_WIDTH 6
`define PCSEQ_PAGE_WIDTH      5
`define PCSEQ_STACK_DEPTH     15
`define PCSEQ_LEN_WIDTH       2

`endif

// ==== design/pcseq_pkg.sv ====
`include "pcseq_map.svh"
`default_nettype none

package pcseq_pkg;

  typedef logic [`PCSEQ_PC_WIDTH-1:0] pcseq_addr_type;

  // Control transfer selected by the decoder for the current fetch
  typedef enum logic [2:0] {
    PCSEQ_OP_NONE   = 3'b000,
    PCSEQ_OP_JUMP   = 3'b001,
    PCSEQ_OP_CALL   = 3'b010,
    PCSEQ_OP_RET    = 3'b011,
    PCSEQ_OP_SHORT  = 3'b100,
    PCSEQ_OP_INTR   = 3'b101
  } pcseq_op_type;

  // One request from the decoder
  typedef struct packed {
    logic                              fetch;
    logic [`PCSEQ_LEN_WIDTH-1:0]       length;
    pcseq_op_type                      op;
    logic                              flag;
    pcseq_addr_type                    target;
    logic [`PCSEQ_SHORT_LSB_WIDTH-1:0] short_imm;
  } pcseq_req_type;

endpackage : pcseq_pkg

`default_nettype wire

// ==== design/pcseq_top.sv ====
`include "pcseq_map.svh"
`default_nettype none

module pcseq_top
  import pcseq_pkg::*;
#(
  parameter int DEPTH = `PCSEQ_STACK_DEPTH
) (
  input  wire logic           core_clk_i,    // Core clock
  input  wire logic           rst_n_i,       // Synchronous reset, active low
  input  wire pcseq_req_type  req_i,         // Decoder request
  output var  pcseq_addr_type program_counter_o, // Current fetch address
  output logic                stack_full_o,  // No free return slot
  output logic                stack_empty_o, // No return address held
  output logic                stack_err_o    // Call or interrupt on full, or return on empty
);

  // ----------------------------------------
  // Local sizes
  // ----------------------------------------
  localparam int ADDR_W = `PCSEQ_PC_WIDTH;
  localparam int LOW_W  = `PCSEQ_SHORT_LSB_WIDTH;
  localparam int PAGE_W = `PCSEQ_PAGE_WIDTH;
  localparam int PTR_W  = $clog2(DEPTH + 1);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // An operation only counts when the decoder qualifies it with fetch
  function automatic logic op_taken(
    input logic         fetch,
    input pcseq_op_type op,
    input pcseq_op_type code
  );
    return fetch && (op == code);
  endfunction : op_taken

  // Upper address bits select the page
  function automatic logic [PAGE_W-1:0] page_of(
    input pcseq_addr_type addr
  );
    return addr[ADDR_W-1 -: PAGE_W];
  endfunction : page_of

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  // Depth counts filled slots; DEPTH itself means full
  pcseq_addr_type   program_counter;
  pcseq_addr_type   next_program_counter;
  pcseq_addr_type   ret_stack [DEPTH];
  wire              pcseq_addr_type slot_hit [DEPTH];
  pcseq_addr_type   top_addr;
  logic [PTR_W-1:0] depth;
  logic [PTR_W-1:0] next_depth;
  logic             err;
  logic             next_err;

  // ----------------------------------------
  // Request fields
  // ----------------------------------------
  wire logic                        req_fetch  = req_i.fetch;
  wire logic [`PCSEQ_LEN_WIDTH-1:0] req_length = req_i.length;
  wire pcseq_op_type                req_op     = req_i.op;
  wire logic                        req_flag   = req_i.flag;
  wire pcseq_addr_type              req_target = req_i.target;
  wire logic [LOW_W-1:0]            req_imm    = req_i.short_imm;

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  wire logic take_call = op_taken(req_fetch, req_op, PCSEQ_OP_CALL);
  wire logic take_intr = op_taken(req_fetch, req_op, PCSEQ_OP_INTR);
  wire logic take_ret  = op_taken(req_fetch, req_op, PCSEQ_OP_RET);

  // ----------------------------------------
  // Stack occupancy
  // ----------------------------------------
  wire logic full  = depth == PTR_W'(DEPTH);
  wire logic empty = depth == '0;
  wire logic push  = (take_call || take_intr) && !full;
  wire logic pop   = take_ret && !empty;

  // ----------------------------------------
  // Candidate addresses
  // ----------------------------------------
  // length advance, wraps
  wire pcseq_addr_type seq_addr =
    pcseq_addr_type'(program_counter + pcseq_addr_type'(req_length));

  // low bits replaced
  // seq_addr already points past the branch, so a branch at a page end keeps the next page.
  wire pcseq_addr_type short_addr = {page_of(seq_addr), req_imm};

  // Interrupts save the preempted fetch address, calls the address after the call
  wire pcseq_addr_type save_addr = take_intr ? program_counter : seq_addr;

  // ----------------------------------------
  // Next address select
  // ----------------------------------------
  // load transfer target
  always_comb begin
    next_program_counter = seq_addr;
    if (!req_fetch) begin
      next_program_counter = program_counter;
    end else begin
      unique case (req_op)
        PCSEQ_OP_JUMP,
        PCSEQ_OP_CALL,
        PCSEQ_OP_INTR: begin
          next_program_counter = req_target;
        end
        PCSEQ_OP_RET: begin
          next_program_counter = empty ? seq_addr : top_addr;
        end
        PCSEQ_OP_SHORT: begin
          next_program_counter = req_flag ? short_addr : seq_addr;
        end
        PCSEQ_OP_NONE: begin
          next_program_counter = seq_addr;
        end
        // The two unused codes advance like a plain fetch
        default: begin
          next_program_counter = seq_addr;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Stack pointer and error
  // ----------------------------------------
  always_comb begin
    next_depth = depth;
    unique case ({push, pop})
      2'b10: begin
        next_depth = depth + 1'b1;
      end
      2'b01: begin
        next_depth = depth - 1'b1;
      end
      default: begin
        next_depth = depth;
      end
    endcase
  end

  // A refused push or pop leaves the stack alone and raises the error pulse; the PC still loads the call target or advances
  assign next_err = ((take_call || take_intr) && full) || (take_ret && empty);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // counter, zero at reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      program_counter <= `PCSEQ_PC_RESET;
    end else begin
      program_counter <= next_program_counter;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      depth <= '0;
    end else begin
      depth <= next_depth;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      err <= 1'b0;
    end else begin
      err <= next_err;
    end
  end

  // ----------------------------------------
  // Return address stack
  // ----------------------------------------
  // return address stack
  // Slots carry no reset: a slot is only read once a push has filled it.
  for (genvar slot = 0; slot < DEPTH; slot++) begin : g_slot
    wire logic slot_we = push && rst_n_i && (depth == PTR_W'(slot));

    always_ff @(posedge core_clk_i) begin
      if (slot_we) begin
        ret_stack[slot] <= save_addr;
      end
    end

    // One-hot pick of the newest slot, so an empty stack never indexes outside the array
    assign slot_hit[slot] = (depth == PTR_W'(slot + 1)) ? ret_stack[slot] : '0;
  end : g_slot

  always_comb begin
    top_addr = '0;
    for (int i = 0; i < DEPTH; i++) begin
      top_addr = top_addr | slot_hit[i];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign program_counter_o = program_counter;
  assign stack_full_o      = full;
  assign stack_empty_o     = empty;
  assign stack_err_o       = err;

endmodule : pcseq_top

`default_nettype wire

// ==== verif/pcseq_sva.sv ====
`default_nettype none
module pcseq_sva import pcseq_pkg::*; #(parameter int DEPTH = 15) (
  input wire logic           core_clk_i, rst_n_i, stack_full_o, stack_empty_o, stack_err_o,
  input wire pcseq_req_type  req_i,
  input wire pcseq_addr_type program_counter_o);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire pcseq_addr_type pc = program_counter_o, nx = pc + 11'(req_i.length);
  wire f = req_i.fetch, plain = f && req_i.op == PCSEQ_OP_NONE;
  wire sh = f && req_i.op == PCSEQ_OP_SHORT && req_i.flag;
  chk_reset_zero: assert property (disable iff (1'b0) !rst_n_i |=> pc == 11'h000) else $error("no reset");
  chk_idle_hold: assert property (!f |=> $stable(pc)) else $error("pc moved");
  chk_plain_step: assert property (plain |=> pc == $past(nx)) else $error("bad step");
  chk_jump_load: assert property (f && req_i.op == PCSEQ_OP_JUMP |=> pc == $past(req_i.target))
    else $error("bad jump");
  chk_ret_empty: assert property (f && req_i.op == PCSEQ_OP_RET && stack_empty_o |=> stack_err_o)
    else $error("no error");
  chk_short_low: assert property (sh |=> pc[5:0] == $past(req_i.short_imm)) else $error("bad low");
  chk_short_page: assert property (sh |=> pc[10:6] == $past(nx[10:6])) else $error("bad page");
  chk_top_wrap: assert property (plain && pc == 11'h7ff && req_i.length == 2'h1 |=> pc == 11'h000)
    else $error("no wrap");
  chk_call_load: assert property (f && (req_i.op == PCSEQ_OP_CALL || req_i.op == PCSEQ_OP_INTR)
    |=> pc == $past(req_i.target)) else $error("bad call");
  chk_full_err: assert property (f && req_i.op == PCSEQ_OP_CALL && stack_full_o |=> stack_err_o)
    else $error("no full error");
  sequence s_call_taken;
    f && req_i.op == PCSEQ_OP_CALL && !stack_full_o;
  endsequence
  sequence s_ret_taken;
    f && req_i.op == PCSEQ_OP_RET;
  endsequence
  chk_call_return: assert property (s_call_taken ##1 s_ret_taken |=> pc == $past(nx, 2))
    else $error("bad return");
endmodule : pcseq_sva
bind pcseq_top pcseq_sva #(.DEPTH(DEPTH)) i_pcseq_sva (.core_clk_i, .rst_n_i, .req_i, .program_counter_o,
  .stack_full_o, .stack_empty_o, .stack_err_o);
`default_nettype wire

// ==== verif/pcseq_rom.sv ====
`default_nettype none
module pcseq_rom import pcseq_pkg::*; (
  input  wire pcseq_addr_type addr_i, // Fetch address
  output logic [1:0]          len_o   // Opcode length
);
  timeunit 1ns; timeprecision 1ns;
  // Two-byte opcodes end in 2'h3, so both lengths occur
  assign len_o = (addr_i[1:0] == 2'h3) ? 2'h2 : 2'h1;
endmodule : pcseq_rom
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns; timeprecision 1ns;
  import pcseq_pkg::*;
  logic core_clk_i = 0, rst_n_i = 0, full, empty, err;
  logic [1:0] rlen;
  pcseq_req_type req = '0;
  pcseq_addr_type pc, e, rt[15];
  int failures = 0, n_tests = 0;
  pcseq_top i_pcseq_top (.core_clk_i, .rst_n_i, .req_i(req), .program_counter_o(pc),
    .stack_full_o(full), .stack_empty_o(empty), .stack_err_o(err));
  pcseq_rom i_pcseq_rom (.addr_i(pc), .len_o(rlen));
  always #5 core_clk_i = ~core_clk_i;
  task chk(input logic [11:0] s, x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("BAD %0t %h %h", $time, s, x);
    end
  endtask : chk
  task step(pcseq_op_type o, logic [1:0] l, pcseq_addr_type t = 0, logic g = 0, logic [5:0] m = 0, logic fe = 1);
    req = {fe, l, o, g, t, m};
    @(negedge core_clk_i);
  endtask : step
  task t_adv;
    chk(pc, 11'h000);
    repeat (4) begin
      e = pc + rlen;
      step(PCSEQ_OP_NONE, rlen);
      chk(pc, e);
    end
    step(PCSEQ_OP_NONE, 2'h2, 0, 0, 0, 0);
    chk(pc, e);
  endtask : t_adv
  task t_nest;
    chk(empty, 1);
    for (int i = 0; i < 15; i++) begin
      rt[i] = (i == 0) ? pc : pc + 11'h001;
      step(i == 0 ? PCSEQ_OP_INTR : PCSEQ_OP_CALL, 2'h1, 11'(i * 64 + 9));
    end
    chk(full, 1);
    step(PCSEQ_OP_CALL, 2'h1, 11'h100);
    chk({err, pc}, 12'h900);
    for (int i = 14; i >= 0; i--) begin
      step(PCSEQ_OP_RET, 2'h1);
      chk(pc, rt[i]);
    end
    step(PCSEQ_OP_RET, 2'h1);
    chk({err, pc}, {1'b1, rt[0] + 11'h001});
  endtask : t_nest
  task t_short;
    step(PCSEQ_OP_JUMP, 2'h1, 11'h03f);
    step(PCSEQ_OP_SHORT, 2'h1, 0, 1, 6'h05);
    chk(pc, 11'h045);
    step(PCSEQ_OP_SHORT, 2'h1, 0, 1, 6'h3a);
    step(PCSEQ_OP_SHORT, 2'h1, 0, 0, 6'h05);
    chk(pc, 11'h07b);
    step(PCSEQ_OP_JUMP, 2'h1, 11'h7ff);
    step(PCSEQ_OP_NONE, 2'h1);
    chk(pc, 11'h000);
  endtask : t_short
  task t_reset;
    step(PCSEQ_OP_CALL, 2'h1, 11'h123);
    chk({empty, pc}, 12'h123);
    rst_n_i = 0;
    @(negedge core_clk_i);
    chk({empty, pc}, 12'h800);
    rst_n_i = 1;
    step(PCSEQ_OP_NONE, 2'h1);
    chk(pc, 11'h001);
  endtask : t_reset
  task finish_test;
    $display("failures %0d tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1;
    t_adv();
    t_nest();
    t_short();
    t_reset();
    finish_test();
  end
  initial begin
    #5000;
    failures++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
